// ==== rtl/lmc_lock_regs.sv ====
`timescale 1ns/1ps
// Behaviour
// [R1] per-PLL slow monitor enable, bits 0..3
// [R2] 4-bit slow set code, 0..10 valid
// [R3] 4-bit slow clear code, two per byte
// [R4] per-PLL enable of clear delay
// [R5] 29-bit clear delay per PLL, little-endian
// [R6] burned bank status 03, 0F, 3F
// [R7] host expects no burn after 3F
// [R8] writing C7 starts a bank burn
// [R9] reload bit copies bank to registers
// [R10] fast-lock extension enables in bits 4..7
// [R11] fast detector asserts lock loss quickly
// [R12] host waits for ready byte 0F
// [R13] delayed clear restarts on renewed loss
module lmc_lock_regs
	import lmc_pkg::*;
#(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned NUM_PLL = 4
) (
	// clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// detector pins, one bit per PLL
	input wire logic [NUM_PLL-1:0] i_fast_err,
	input wire logic [NUM_PLL-1:0] i_slow_loss,
	input wire logic [NUM_PLL-1:0] i_slow_ok,
	// lock loss indication and interrupt
	output logic [NUM_PLL-1:0] o_lock_loss,
	output logic o_irq,
	// fast detector settings, nibble or pair per PLL
	output logic [15:0] o_fast_win_sel,
	output logic [7:0] o_fast_val_sel,
	output logic [15:0] o_fast_set_thr,
	output logic [15:0] o_fast_clr_thr,
	// slow detector settings
	output logic [15:0] o_slow_win_sel,
	output logic [7:0] o_slow_val_sel,
	output logic [15:0] o_slow_set_thr,
	output logic [15:0] o_slow_clr_thr,
	// fast-lock extension enables
	output logic [NUM_PLL-1:0] o_ext_en
);
	typedef struct packed {
		lmc_cfg_t cfg;
		logic [7:0] burn_cmd;
		logic [INT_W-1:0] sts;
		logic [INT_W-1:0] msk;
		logic [INT_W-1:0] snap;
		logic have;
		logic err;
		logic [31:0] rdata;
		logic irq;
		logic burn_go;
		logic load_go;
	} lmc_reg_st_t;
	lmc_reg_st_t s, n;

	// bus decode
	logic [7:0] idx;
	logic ok_addr;
	logic [7:0] rd_b;
	logic rd_hit;
	logic [7:0] wb;
	logic [INT_W-1:0] clr;
	logic [INT_W-1:0] ev;
	// per-PLL monitor signals
	logic [NUM_PLL-1:0] lol;
	logic [NUM_PLL-1:0] lol_rise;
	logic [NUM_PLL-1:0] code_bad;
	logic [15:0] slow_set;
	logic [15:0] slow_clr;
	// bank controller
	logic [CFG_W-1:0] nv_image;
	logic [7:0] nv_bank_sts;
	logic nv_busy;
	logic nv_burn_done;
	logic nv_load_done;
	logic nv_refused;

	// registers are one byte per word; upper address bits must be zero
	assign idx = i_paddr[9:2];
	assign ok_addr = (i_paddr[1:0] == 2'h0) &&
		(i_paddr[ADDR_W-1:10] == '0);
	assign wb = i_pwdata[7:0];

	// read mux; delay words are a loop over PLL and byte
	always_comb begin
		rd_b = 8'h00;
		rd_hit = 1'b1;
		if (idx == IX_FAST_EN) begin
			rd_b = s.cfg.fast_en;
		end else if (idx == IX_FAST_WIN_AB) begin
			rd_b = s.cfg.fast_win_ab;
		end else if (idx == IX_FAST_WIN_CD) begin
			rd_b = s.cfg.fast_win_cd;
		end else if (idx == IX_FAST_VAL) begin
			rd_b = s.cfg.fast_val;
		end else if (idx == IX_FAST_SET_AB) begin
			rd_b = s.cfg.fast_set_ab;
		end else if (idx == IX_FAST_SET_CD) begin
			rd_b = s.cfg.fast_set_cd;
		end else if (idx == IX_FAST_CLR_AB) begin
			rd_b = s.cfg.fast_clr_ab;
		end else if (idx == IX_FAST_CLR_CD) begin
			rd_b = s.cfg.fast_clr_cd;
		end else if (idx == IX_SLOW_EN) begin
			rd_b = s.cfg.slow_en; // R1
		end else if (idx == IX_SLOW_WIN_AB) begin
			rd_b = s.cfg.slow_win_ab;
		end else if (idx == IX_SLOW_WIN_CD) begin
			rd_b = s.cfg.slow_win_cd;
		end else if (idx == IX_SLOW_VAL) begin
			rd_b = s.cfg.slow_val;
		end else if (idx == IX_SLOW_SET_AB) begin
			rd_b = s.cfg.slow_set_ab; // R2
		end else if (idx == IX_SLOW_SET_CD) begin
			rd_b = s.cfg.slow_set_cd; // R2
		end else if (idx == IX_SLOW_CLR_AB) begin
			rd_b = s.cfg.slow_clr_ab; // R3
		end else if (idx == IX_SLOW_CLR_CD) begin
			rd_b = s.cfg.slow_clr_cd; // R3
		end else if (idx == IX_DLY_EN) begin
			rd_b = s.cfg.dly_en; // R4
		end else if (idx == IX_INT_STS) begin
			rd_b = 8'(s.sts);
		end else if (idx == IX_INT_MSK) begin
			rd_b = 8'(s.msk);
		end else if (idx == IX_LOCK_STS) begin
			rd_b = {code_bad, lol};
		end else if (idx == IX_BANK_STS) begin
			rd_b = nv_bank_sts; // R6
		end else if (idx == IX_BURN) begin
			rd_b = s.burn_cmd;
		end else if (idx == IX_RELOAD) begin
			rd_b = 8'h00;
		end else if (idx == IX_EXT_EN) begin
			rd_b = s.cfg.ext_en; // R10
		end else if (idx == IX_READY) begin
			// not ready while a burn or reload is running
			rd_b = nv_busy ? BUSY_CODE : READY_CODE; // R12
		end else begin
			rd_hit = 1'b0;
			for (int p = 0; p < 4; p++) begin
				for (int k = 0; k < 4; k++) begin
					if (idx == 8'(IX_DLY[p] + 8'(k))) begin
						rd_hit = 1'b1;
						rd_b = s.cfg.dly[p][8*k+:8]; // R5
					end
				end
			end
		end
		if (!ok_addr) begin
			rd_hit = 1'b0;
		end
	end

	// events: lock loss rises, burn done, reload done, burn refused
	assign ev = {nv_refused, nv_load_done, nv_burn_done, lol_rise};

	// apb: read data is captured in the setup cycle, write and
	// read side effects happen at the completing access edge
	always_comb begin
		n = s;
		n.burn_go = 1'b0;
		n.load_go = 1'b0;
		clr = '0;
		if (i_psel && !s.have) begin
			n.have = 1'b1;
			n.rdata = {24'h000000, rd_b};
			n.err = ~rd_hit;
			n.snap = (idx == IX_INT_STS && !i_pwrite) ? s.sts : '0;
		end else if (i_psel && i_penable && s.have) begin
			n.have = 1'b0;
			if (!s.err && !i_pwrite) begin
				// only bits seen by the read are cleared
				clr = s.snap;
			end else if (!s.err) begin
				if (idx == IX_FAST_EN) begin
					n.cfg.fast_en = wb & MSK_NIB_LO; // R11
				end else if (idx == IX_FAST_WIN_AB) begin
					n.cfg.fast_win_ab = wb;
				end else if (idx == IX_FAST_WIN_CD) begin
					n.cfg.fast_win_cd = wb;
				end else if (idx == IX_FAST_VAL) begin
					n.cfg.fast_val = wb;
				end else if (idx == IX_FAST_SET_AB) begin
					n.cfg.fast_set_ab = wb;
				end else if (idx == IX_FAST_SET_CD) begin
					n.cfg.fast_set_cd = wb;
				end else if (idx == IX_FAST_CLR_AB) begin
					n.cfg.fast_clr_ab = wb;
				end else if (idx == IX_FAST_CLR_CD) begin
					n.cfg.fast_clr_cd = wb;
				end else if (idx == IX_SLOW_EN) begin
					n.cfg.slow_en = wb & MSK_NIB_LO; // R1
				end else if (idx == IX_SLOW_WIN_AB) begin
					n.cfg.slow_win_ab = wb;
				end else if (idx == IX_SLOW_WIN_CD) begin
					n.cfg.slow_win_cd = wb;
				end else if (idx == IX_SLOW_VAL) begin
					n.cfg.slow_val = wb;
				end else if (idx == IX_SLOW_SET_AB) begin
					n.cfg.slow_set_ab = wb; // R2
				end else if (idx == IX_SLOW_SET_CD) begin
					n.cfg.slow_set_cd = wb; // R2
				end else if (idx == IX_SLOW_CLR_AB) begin
					n.cfg.slow_clr_ab = wb; // R3
				end else if (idx == IX_SLOW_CLR_CD) begin
					n.cfg.slow_clr_cd = wb; // R3
				end else if (idx == IX_DLY_EN) begin
					n.cfg.dly_en = wb & MSK_NIB_LO; // R4
				end else if (idx == IX_INT_MSK) begin
					n.msk = wb[INT_W-1:0];
				end else if (idx == IX_BURN) begin
					n.burn_cmd = wb;
					n.burn_go = (wb == BURN_KEY); // R8
				end else if (idx == IX_RELOAD) begin
					n.load_go = wb[0]; // R9
				end else if (idx == IX_EXT_EN) begin
					n.cfg.ext_en = wb & MSK_NIB_HI; // R10
				end else begin
					// top delay byte keeps bits 28..24 only
					for (int p = 0; p < 4; p++) begin
						for (int k = 0; k < 4; k++) begin
							if (idx == 8'(IX_DLY[p] + 8'(k))) begin
								n.cfg.dly[p][8*k+:8] =
									(k == 3) ? (wb & MSK_DLY_TOP) : wb; // R5
							end
						end
					end
				end
			end
		end
		// a new event outweighs a clear in the same cycle
		n.sts = (s.sts & ~clr) | ev;
		if (nv_load_done) begin
			n.cfg = lmc_cfg_t'(nv_image); // R9
		end
		n.irq = |(n.sts & n.msk);
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s <= '0;
		end else if (i_ce) begin
			s <= n;
		end
	end

	// a frozen clock enable also holds off the bus
	assign o_pready = i_ce & s.have & i_penable;
	assign o_prdata = s.rdata;
	assign o_pslverr = o_pready & s.err;
	assign o_irq = s.irq;

	// threshold nibbles, PLL a in the low nibble
	assign slow_set = {s.cfg.slow_set_cd, s.cfg.slow_set_ab};
	assign slow_clr = {s.cfg.slow_clr_cd, s.cfg.slow_clr_ab};

	// one lock monitor per PLL
	for (genvar g = 0; g < NUM_PLL; g++) begin : g_pll
		assign code_bad[g] = (slow_set[4*g+:4] > THR_MAX_CODE) |
			(slow_clr[4*g+:4] > THR_MAX_CODE); // R2 R3
		lmc_lol u_lol (
			.i_core_clk(i_core_clk),
			.i_nrst(i_nrst),
			.i_ce(i_ce),
			.i_fast_en(s.cfg.fast_en[g]),
			.i_slow_en(s.cfg.slow_en[g]),
			.i_code_ok(~code_bad[g]),
			.i_dly_en(s.cfg.dly_en[g]),
			.i_dly(s.cfg.dly[g][DLY_W-1:0]),
			.i_fast_err(i_fast_err[g]),
			.i_slow_loss(i_slow_loss[g]),
			.i_slow_ok(i_slow_ok[g]),
			.o_lock_loss(lol[g]),
			.o_rise(lol_rise[g])
		);
	end

	// bank burn and reload
	lmc_nvm #(
		.W(CFG_W)
	) u_nvm (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_burn(s.burn_go),
		.i_load(s.load_go),
		.i_image(s.cfg),
		.o_image(nv_image),
		.o_bank_sts(nv_bank_sts),
		.o_busy(nv_busy),
		.o_burn_done(nv_burn_done),
		.o_load_done(nv_load_done),
		.o_refused(nv_refused)
	);

	// lock loss and configuration straight from registers
	assign o_lock_loss = lol;
	assign o_fast_win_sel = {s.cfg.fast_win_cd, s.cfg.fast_win_ab};
	assign o_fast_val_sel = s.cfg.fast_val;
	assign o_fast_set_thr = {s.cfg.fast_set_cd, s.cfg.fast_set_ab};
	assign o_fast_clr_thr = {s.cfg.fast_clr_cd, s.cfg.fast_clr_ab};
	assign o_slow_win_sel = {s.cfg.slow_win_cd, s.cfg.slow_win_ab};
	assign o_slow_val_sel = s.cfg.slow_val;
	assign o_slow_set_thr = slow_set;
	assign o_slow_clr_thr = slow_clr;
	assign o_ext_en = s.cfg.ext_en[7:4]; // R10
endmodule

// ==== rtl/lmc_pkg.sv ====
package lmc_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [7:0] IX_FAST_EN = 8'h92;
	localparam logic [7:0] IX_FAST_WIN_AB = 8'h93;
	localparam logic [7:0] IX_FAST_WIN_CD = 8'h94;
	localparam logic [7:0] IX_FAST_VAL = 8'h95;
	localparam logic [7:0] IX_FAST_SET_AB = 8'h96;
	localparam logic [7:0] IX_FAST_SET_CD = 8'h97;
	localparam logic [7:0] IX_FAST_CLR_AB = 8'h98;
	localparam logic [7:0] IX_FAST_CLR_CD = 8'h99;
	localparam logic [7:0] IX_SLOW_EN = 8'h9A;
	localparam logic [7:0] IX_SLOW_WIN_AB = 8'h9B;
	localparam logic [7:0] IX_SLOW_WIN_CD = 8'h9C;
	localparam logic [7:0] IX_SLOW_VAL = 8'h9D;
	localparam logic [7:0] IX_SLOW_SET_AB = 8'h9E;
	localparam logic [7:0] IX_SLOW_SET_CD = 8'h9F;
	localparam logic [7:0] IX_SLOW_CLR_AB = 8'hA0;
	localparam logic [7:0] IX_SLOW_CLR_CD = 8'hA1;
	localparam logic [7:0] IX_DLY_EN = 8'hA2;
	// first byte of each 29-bit clear delay, PLL d..a
	localparam logic [3:0][7:0] IX_DLY = {8'hB3, 8'hAE, 8'hA9, 8'hA4};
	localparam logic [7:0] IX_INT_STS = 8'hC0;
	localparam logic [7:0] IX_INT_MSK = 8'hC1;
	localparam logic [7:0] IX_LOCK_STS = 8'hC2;
	localparam logic [7:0] IX_BANK_STS = 8'hE2;
	localparam logic [7:0] IX_BURN = 8'hE3;
	localparam logic [7:0] IX_RELOAD = 8'hE4;
	localparam logic [7:0] IX_EXT_EN = 8'hE5;
	localparam logic [7:0] IX_READY = 8'hFE;
	// field masks and codes
	localparam logic [7:0] MSK_NIB_LO = 8'h0F;
	localparam logic [7:0] MSK_NIB_HI = 8'hF0;
	localparam logic [7:0] MSK_DLY_TOP = 8'h1F;
	localparam logic [3:0] THR_MAX_CODE = 4'hA;
	localparam logic [7:0] BANK_NONE = 8'h03;
	localparam logic [7:0] BANK_ONE = 8'h0F;
	localparam logic [7:0] BANK_TWO = 8'h3F;
	localparam logic [1:0] NV_BANKS = 2'h2;
	localparam logic [7:0] BURN_KEY = 8'hC7;
	localparam logic [7:0] READY_CODE = 8'h0F;
	localparam logic [7:0] BUSY_CODE = 8'h00;
	// interrupt status bits: 3..0 lock loss rise per PLL
	localparam int unsigned INT_W = 7;
	// timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned BURN_TIME_US = 10;
	localparam int unsigned LOAD_TIME_US = 2;
	localparam int unsigned BURN_CYC =
		(BURN_TIME_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int unsigned LOAD_CYC =
		(LOAD_TIME_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int unsigned NV_TMR_W = 10;
	localparam int unsigned DLY_W = 29;

	typedef enum logic [1:0] {NV_IDLE, NV_BURN, NV_LOAD} lmc_nv_t;

	// volatile configuration image, also the burned bank contents
	typedef struct packed {
		logic [7:0] fast_en;
		logic [7:0] fast_win_ab;
		logic [7:0] fast_win_cd;
		logic [7:0] fast_val;
		logic [7:0] fast_set_ab;
		logic [7:0] fast_set_cd;
		logic [7:0] fast_clr_ab;
		logic [7:0] fast_clr_cd;
		logic [7:0] slow_en;
		logic [7:0] slow_win_ab;
		logic [7:0] slow_win_cd;
		logic [7:0] slow_val;
		logic [7:0] slow_set_ab;
		logic [7:0] slow_set_cd;
		logic [7:0] slow_clr_ab;
		logic [7:0] slow_clr_cd;
		logic [7:0] dly_en;
		logic [3:0][31:0] dly;
		logic [7:0] ext_en;
	} lmc_cfg_t;

	localparam int unsigned CFG_W = $bits(lmc_cfg_t);
endpackage

// ==== rtl/lmc_lol.sv ====
`timescale 1ns/1ps
module lmc_lol
	import lmc_pkg::*;
(
	// clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// configuration
	input wire logic i_fast_en,
	input wire logic i_slow_en,
	input wire logic i_code_ok,
	input wire logic i_dly_en,
	input wire logic [DLY_W-1:0] i_dly,
	// detector pins
	input wire logic i_fast_err,
	input wire logic i_slow_loss,
	input wire logic i_slow_ok,
	// indication
	output logic o_lock_loss,
	output logic o_rise
);
	typedef struct packed {
		logic [2:0] fe;
		logic [2:0] sl;
		logic [2:0] so;
		logic fe_f;
		logic sl_f;
		logic so_f;
		logic lol;
		logic rise;
		logic [DLY_W-1:0] cnt;
	} lmc_lol_st_t;
	lmc_lol_st_t s, n;
	logic slow_on;
	logic loss;
	logic clr_ok;

	// pins pass three flops; a change counts when stages two and three agree
	always_comb begin
		n = s;
		n.rise = 1'b0;
		n.fe = {s.fe[1:0], i_fast_err};
		n.sl = {s.sl[1:0], i_slow_loss};
		n.so = {s.so[1:0], i_slow_ok};
		if (s.fe[1] == s.fe[2]) n.fe_f = s.fe[2];
		if (s.sl[1] == s.sl[2]) n.sl_f = s.sl[2];
		if (s.so[1] == s.so[2]) n.so_f = s.so[2];
		// reserved threshold codes keep the slow monitor off
		slow_on = i_slow_en & i_code_ok; // R1 R2 R3
		loss = (i_fast_en & s.fe_f) | (slow_on & s.sl_f); // R11
		clr_ok = slow_on ? s.so_f : 1'b1;
		if (!(i_fast_en | slow_on)) begin
			n.lol = 1'b0;
			n.cnt = '0;
		end else if (loss) begin
			n.lol = 1'b1; // R11
			n.rise = ~s.lol;
			n.cnt = '0; // R13
		end else if (s.lol && clr_ok) begin
			if (!i_dly_en) begin
				n.lol = 1'b0; // R4
			end else if (s.cnt >= i_dly) begin
				n.lol = 1'b0; // R5 R13
				n.cnt = '0;
			end else begin
				n.cnt = s.cnt + 1'b1;
			end
		end else begin
			n.cnt = '0; // R13
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s <= '0;
		end else if (i_ce) begin
			s <= n;
		end
	end

	assign o_lock_loss = s.lol;
	assign o_rise = s.rise;
endmodule

// ==== rtl/lmc_nvm.sv ====
`timescale 1ns/1ps
module lmc_nvm
	import lmc_pkg::*;
#(
	parameter int unsigned W = 8
) (
	// clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// commands
	input wire logic i_burn,
	input wire logic i_load,
	input wire logic [W-1:0] i_image,
	// results
	output logic [W-1:0] o_image,
	output logic [7:0] o_bank_sts,
	output logic o_busy,
	output logic o_burn_done,
	output logic o_load_done,
	output logic o_refused
);
	typedef struct packed {
		lmc_nv_t st;
		logic [1:0] used;
		logic [NV_TMR_W-1:0] tmr;
		logic [1:0][W-1:0] bank;
		logic [W-1:0] img;
		logic bdone;
		logic ldone;
		logic refd;
	} lmc_nvs_t;
	lmc_nvs_t s, n;

	// commands arriving while busy are dropped
	always_comb begin
		n = s;
		n.bdone = 1'b0;
		n.ldone = 1'b0;
		n.refd = 1'b0;
		case (s.st)
		NV_IDLE: begin
			if (i_burn) begin
				if (s.used == NV_BANKS) begin
					n.refd = 1'b1; // R7
				end else begin
					// image frozen at start so later writes cannot tear it
					n.st = NV_BURN; // R8
					n.img = i_image;
					n.tmr = NV_TMR_W'(BURN_CYC - 1);
				end
			end else if (i_load) begin
				n.st = NV_LOAD; // R9
				n.tmr = NV_TMR_W'(LOAD_CYC - 1);
			end
		end
		NV_BURN: begin
			if (s.tmr == '0) begin
				n.bank[s.used[0]] = s.img; // R8
				n.used = s.used + 2'h1;
				n.bdone = 1'b1;
				n.st = NV_IDLE;
			end else begin
				n.tmr = s.tmr - 1'b1;
			end
		end
		default: begin
			if (s.tmr == '0) begin
				// latest burned bank, or reset image if none
				n.img = (s.used == 2'h0) ? '0 : s.bank[s.used[1]]; // R9
				n.ldone = 1'b1;
				n.st = NV_IDLE;
			end else begin
				n.tmr = s.tmr - 1'b1;
			end
		end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s <= '0;
		end else if (i_ce) begin
			s <= n;
		end
	end

	// burned bank count as thermometer code
	assign o_bank_sts = (s.used == 2'h0) ? BANK_NONE :
		(s.used == 2'h1) ? BANK_ONE : BANK_TWO; // R6
	assign o_image = s.img;
	assign o_busy = (s.st != NV_IDLE);
	assign o_burn_done = s.bdone;
	assign o_load_done = s.ldone;
	assign o_refused = s.refd;
endmodule

// ==== bench/lmc_lock_regs_assertions.sv ====
`timescale 1ns/1ps
module lmc_lock_regs_chk
	import lmc_pkg::*;
#(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned NUM_PLL = 4
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// apb side
	input wire logic i_ce,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	// monitor pins and settings
	input wire logic [NUM_PLL-1:0] i_fast_err,
	input wire logic [NUM_PLL-1:0] i_slow_loss,
	input wire logic [NUM_PLL-1:0] o_lock_loss,
	input wire logic [15:0] o_slow_set_thr,
	input wire logic [15:0] o_slow_clr_thr,
	input wire logic [NUM_PLL-1:0] o_ext_en
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	// completed write, address compared per property
	wire logic wr_done = i_psel && i_penable && o_pready && i_pwrite;

	// the two steps of one bus transfer
	sequence s_setup;
		i_psel && !i_penable && i_ce;
	endsequence
	sequence s_access;
		i_psel && i_penable && i_ce;
	endsequence

	a_pready_zero_wait: assert property (s_setup ##1 s_access |-> o_pready)
		else $error("ready missing in first access cycle");
	a_ready_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside an access phase");
	a_err_misalign: assert property (o_pready && i_paddr[1:0] != 2'h0 |-> o_pslverr)
		else $error("misaligned access not refused");
	a_rdata_byte: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_ext_write: assert property (wr_done && i_paddr == ADDR_W'({IX_EXT_EN, 2'h0})
		|=> o_ext_en == $past(i_pwdata[7:4]))
		else $error("extension enables not taken from bits 7:4");
	a_set_write: assert property (wr_done && i_paddr == ADDR_W'({IX_SLOW_SET_AB, 2'h0})
		|=> o_slow_set_thr[7:0] == $past(i_pwdata[7:0]))
		else $error("slow set codes not stored");
	a_clr_write: assert property (wr_done && i_paddr == ADDR_W'({IX_SLOW_CLR_CD, 2'h0})
		|=> o_slow_clr_thr[15:8] == $past(i_pwdata[7:0]))
		else $error("slow clear codes not stored");
	// a rise needs a loss pin seen through the synchroniser
	a_loss_cause: assert property ($rose(o_lock_loss[0])
		|-> $past(i_fast_err[0] || i_slow_loss[0], 4))
		else $error("lock loss rose without a loss pin");
endmodule

// ==== bench/lmc_lock_regs_tb.sv ====
`timescale 1ns/1ps
module lmc_lock_regs_tb
	import lmc_pkg::*;
;
	// table of write value and masked read back
	localparam logic [7:0] TIX [11] = '{IX_SLOW_EN, IX_SLOW_SET_AB,
		IX_SLOW_CLR_CD, IX_DLY_EN, IX_EXT_EN, IX_FAST_WIN_CD,
		IX_FAST_VAL, IX_FAST_SET_AB, IX_FAST_CLR_CD,
		IX_SLOW_WIN_AB, IX_SLOW_VAL};
	localparam logic [7:0] TWD [11] = '{8'hFF, 8'h5A, 8'hA3, 8'hFF,
		8'hFF, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC};
	localparam logic [7:0] TEX [11] = '{8'h0F, 8'h5A, 8'hA3, 8'h0F,
		8'hF0, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	// low address bits, nonzero only for the misaligned probe
	logic [1:0] lo = 2'h0;
	logic [15:0] fws, fst, fct, sws;
	logic [7:0] fvs, svs;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] fast_err = 4'h0;
	logic [3:0] slow_loss = 4'h0;
	logic [3:0] slow_ok = 4'hF;
	logic pready, pslverr, irq, er;
	logic [31:0] prdata, rd;
	logic [3:0] lol, ext;
	logic [15:0] sset, sclr;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;

	lmc_lock_regs i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_ce(ce),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_fast_err(fast_err),
		.i_slow_loss(slow_loss), .i_slow_ok(slow_ok), .o_lock_loss(lol),
		.o_irq(irq), .o_fast_win_sel(fws), .o_fast_val_sel(fvs),
		.o_fast_set_thr(fst), .o_fast_clr_thr(fct), .o_slow_win_sel(sws),
		.o_slow_val_sel(svs), .o_slow_set_thr(sset), .o_slow_clr_thr(sclr),
		.o_ext_en(ext));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// hang guard, well above the two burns and the reload
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// one apb transfer; the idle edge after it keeps drivers single per step
	task automatic xfer(input logic wr, input logic [7:0] ix,
		input logic [7:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'h0, ix, lo};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		// no own limit: only the hang guard ends a stalled access
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdc(input logic [7:0] ix, input logic [31:0] ex);
		xfer(1'b0, ix, 8'h00);
		chk($sformatf("reg %h", ix), ex, rd);
	endtask

	// poll the ready byte, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			xfer(1'b0, IX_READY, 8'h00);
			n++;
		end while (rd !== {24'h0, READY_CODE} && n < 200);
		chk("ready byte", {24'h0, READY_CODE}, rd);
	endtask

	task automatic wait_lol(input logic v, input int lim);
		int n;
		n = 0;
		while (lol[0] !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk("lock loss a", {31'h0, v}, {31'h0, lol[0]});
	endtask

	// irq is registered: look between edges, resume on a rising edge
	task automatic irqc(input logic ex);
		repeat (2) @(negedge clk);
		chk("irq", {31'h0, ex}, {31'h0, irq});
		@(posedge clk);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rdc(IX_READY, {24'h0, READY_CODE});
		rdc(IX_BANK_STS, {24'h0, BANK_NONE});
		for (int i = 0; i < 11; i++) begin
			xfer(1'b1, TIX[i], TWD[i]);
			rdc(TIX[i], {24'h0, TEX[i]});
		end
		chk("slow set", 32'h5A, {16'h0, sset});
		chk("slow clr", 32'hA300, {16'h0, sclr});
		chk("ext en", 32'hF, {28'h0, ext});
		chk("fast win", 32'h1200, {16'h0, fws});
		chk("fast val", 32'h34, {24'h0, fvs});
		chk("fast set", 32'h56, {16'h0, fst});
		chk("fast clr", 32'h7800, {16'h0, fct});
		chk("slow win", 32'h9A, {16'h0, sws});
		chk("slow val", 32'hBC, {24'h0, svs});
		xfer(1'b1, IX_DLY[1] + 8'h3, 8'hFF);
		rdc(IX_DLY[1] + 8'h3, 32'h1F);
		xfer(1'b1, IX_DLY[0], 8'h40);
		// unmapped index and read-only byte
		xfer(1'b0, 8'h00, 8'h00);
		chk("unmapped err", 32'h1, {31'h0, er});
		// misaligned write is refused and leaves the byte alone
		lo = 2'h2;
		xfer(1'b1, IX_EXT_EN, 8'h00);
		lo = 2'h0;
		chk("misaligned err", 32'h1, {31'h0, er});
		chk("ext kept", 32'hF, {28'h0, ext});
		xfer(1'b1, IX_BANK_STS, 8'hFF);
		rdc(IX_BANK_STS, {24'h0, BANK_NONE});
		// fast loss on pll a, interrupt and clear on read
		xfer(1'b1, IX_INT_MSK, 8'h7F);
		xfer(1'b1, IX_FAST_EN, 8'h01);
		fast_err <= 4'h1;
		wait_lol(1'b1, 20);
		rdc(IX_INT_MSK, 32'h7F);
		irqc(1'b1);
		rdc(IX_INT_STS, 32'h01);
		irqc(1'b0);
		// delayed clear of 0x40 cycles, restarted by a two-cycle loss;
		// a single-cycle pulse never gets past the pin filter
		fast_err <= 4'h0;
		repeat (40) @(posedge clk);
		chk("clear held", 32'h1, {31'h0, lol[0]});
		fast_err <= 4'h1;
		repeat (2) @(posedge clk);
		fast_err <= 4'h0;
		repeat (40) @(posedge clk);
		chk("clear restarted", 32'h1, {31'h0, lol[0]});
		wait_lol(1'b0, 60);
		// reserved code flagged in lock status
		xfer(1'b1, IX_SLOW_SET_AB, 8'h5B);
		rdc(IX_LOCK_STS, 32'h10);
		// wrong key does nothing, then two burns and a refused one
		xfer(1'b1, IX_INT_MSK, 8'h00);
		xfer(1'b1, IX_BURN, 8'hC6);
		rdc(IX_READY, {24'h0, READY_CODE});
		xfer(1'b1, IX_BURN, BURN_KEY);
		rdc(IX_READY, {24'h0, BUSY_CODE});
		wait_ready();
		rdc(IX_BANK_STS, {24'h0, BANK_ONE});
		irqc(1'b0);
		rdc(IX_INT_STS, 32'h10);
		xfer(1'b1, IX_BURN, BURN_KEY);
		wait_ready();
		rdc(IX_BANK_STS, {24'h0, BANK_TWO});
		xfer(1'b1, IX_BURN, BURN_KEY);
		wait_ready();
		rdc(IX_BANK_STS, {24'h0, BANK_TWO});
		rdc(IX_INT_STS, 32'h50);
		// reload restores the burned image
		xfer(1'b1, IX_INT_MSK, 8'h20);
		xfer(1'b1, IX_EXT_EN, 8'h00);
		xfer(1'b1, IX_RELOAD, 8'h01);
		// a frozen enable stalls the reload countdown
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		ce <= 1'b1;
		rdc(IX_READY, {24'h0, BUSY_CODE});
		wait_ready();
		irqc(1'b1);
		rdc(IX_EXT_EN, 32'hF0);
		rdc(IX_RELOAD, 32'h0);
		give_verdict();
	end
endmodule

bind lmc_lock_regs lmc_lock_regs_chk #(.ADDR_W(ADDR_W), .NUM_PLL(NUM_PLL))
	i_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ce(i_ce),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
	.o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_fast_err(i_fast_err),
	.i_slow_loss(i_slow_loss), .o_lock_loss(o_lock_loss),
	.o_slow_set_thr(o_slow_set_thr), .o_slow_clr_thr(o_slow_clr_thr),
	.o_ext_en(o_ext_en));
